// [rtl/drv_prot_pkg.sv]
// package: register map, field positions and reset values for the output driver register bank
package drv_prot_pkg;
  localparam logic [7:0] page_select_off = 8'h00;
  localparam logic [7:0] driver_error_control_off = 8'h1e;
  localparam logic [7:0] headphone_driver_control_off = 8'h1f;
  localparam logic [7:0] speaker_amp_control_off = 8'h20;
  localparam logic [7:0] pin_volume_gain_readout_off = 8'h75;
  localparam logic [7:0] gain_page = 8'h00;
  localparam logic [7:0] driver_page = 8'h01;
  localparam logic [7:0] page_select_rst = 8'h00;
  localparam logic [7:0] driver_error_control_rst = 8'h00;
  localparam logic [7:0] headphone_driver_control_rst = 8'h04;
  localparam logic [7:0] speaker_amp_control_rst = 8'h06;
  localparam logic [6:0] gain_code_rst = 7'h00;
  localparam logic [6:0] gain_code_reserved = 7'h7f;
  localparam logic [6:0] gain_code_min = 7'h7e;
  localparam int hp_left_bit = 7;
  localparam int hp_right_bit = 6;
  localparam int hp_resp_bit = 1;
  localparam int hp_short_bit = 0;
  localparam int sp_left_bit = 7;
  localparam int sp_right_bit = 6;
  localparam int sp_short_bit = 0;
  localparam int hp_keep_bit = 1;
  localparam int sp_keep_bit = 0;
  localparam logic [7:0] hp_stored_mask = 8'hde;
  localparam logic [7:0] sp_stored_mask = 8'hfe;
  localparam logic [7:0] err_stored_mask = 8'h03;
  localparam logic [1:0] cm_1v35 = 2'h0;
  localparam logic [1:0] cm_1v50 = 2'h1;
  localparam logic [1:0] cm_1v65 = 2'h2;
  localparam logic [1:0] cm_1v80 = 2'h3;
  // control outputs toward the analog drivers
  typedef struct packed {
    logic left_headphone_driver;
    logic right_headphone_driver;
    logic left_speaker_driver;
    logic right_speaker_driver;
    logic [1:0] common_mode_sel;
    logic hp_power_down_on_short;
  } drv_ctrl_t;
endpackage : drv_prot_pkg

// [rtl/output_driver_protection_regs.sv]
// output driver control and short-circuit protection register bank
`timescale 1ns/1ps
// Summary of operation
// (RULE_01) Gain readout is a 7-bit read-only code where zero is +18 dB, stepping down 0.5 dB.
// (RULE_02) The gain code skips 0 dB, going from +0.5 dB at 0x23 to -0.5 dB at 0x24.
// (RULE_03) The lowest gain is -63 dB at 0x7e and code 0x7f is reserved and never reported.
// (RULE_04) Software writes only zero to bit 7 of the gain readout; the low bits are read-only.
// (RULE_05) The page register holds an 8-bit page number, resets to zero and selects the page.
// (RULE_06) Software does not write the reserved registers of page zero or page one.
// (RULE_07) With headphone keep bit 0 and response select 1, a short clears both headphone bits.
// (RULE_08) With speaker keep bit 0, a short clears both speaker power-up bits.
// (RULE_09) Bits 7 and 6 of the headphone register power up left and right drivers, reset 0.
// (RULE_10) Bits 4:3 of the headphone register select common mode 1.35, 1.5, 1.65 or 1.8 V.
// (RULE_11) Response select 0 only limits load current on a short, 1 powers the driver down.
// (RULE_12) Bit 0 of the headphone register reads 1 while a headphone short is detected.
// (RULE_13) Software writes 1 to headphone bit 2, which resets to 1, and 0 to bit 5.
// (RULE_14) Speaker power-up bits are bits 7 and 6 of the speaker amplifier register.
// (RULE_15) A short clears power-up bits in the cycle it is sampled, and reads see it.
module output_driver_protection_regs
  import drv_prot_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [7:0] page,
  input wire logic hp_short_pin,
  input wire logic sp_short_pin,
  input wire logic [6:0] gain_code_in,
  output drv_ctrl_t drv_ctrl
);
  // register map; page_select answers at offset 0x00 on every page, the rest need a page:
  //   page 0, 0x75: pin-volume gain code in bits 6:0, bit 7 always reads zero
  //   page 1, 0x1e: error control, bit 1 keeps headphone and bit 0 keeps speaker power-up
  //   page 1, 0x1f: headphone drivers, power-up 7:6, common mode 4:3, short response 1
  //   page 1, 0x20: speaker amplifier, power-up 7:6, short flag 0
  // every other offset reads zero and ignores writes, so reserved space stays inert
  // limitation: reads are registered, rdata changes only on the edge that samples rd_en
  // a short overrides a same-cycle power-up write, trading host intent for driver safety

  logic [7:0] page_reg;
  logic [7:0] err_reg;
  logic [7:0] hp_reg;
  logic [7:0] sp_reg;
  logic [6:0] gain_reg;
  logic [1:0] hp_sync_reg;
  logic [1:0] sp_sync_reg;
  logic [6:0] gain_meta_reg;
  logic [6:0] gain_sync_reg;
  logic hp_short;
  logic sp_short;
  logic wr_err;
  logic wr_hp;
  logic wr_sp;
  logic [7:0] hp_next;
  logic [7:0] sp_next;
  logic [7:0] rdata_next;
  logic [6:0] gain_hold_reg;
  logic gain_steady;
  logic wr_page;
  logic sel_gain;
  logic sel_err;
  logic sel_hp;
  logic sel_sp;

  // short flags and gain code come from the analog side, so two flops each
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hp_sync_reg <= 2'h0;
      sp_sync_reg <= 2'h0;
      gain_meta_reg <= gain_code_rst;
      gain_sync_reg <= gain_code_rst;
    end else begin
      hp_sync_reg <= {hp_sync_reg[0], hp_short_pin};
      sp_sync_reg <= {sp_sync_reg[0], sp_short_pin};
      gain_meta_reg <= gain_code_in;
      gain_sync_reg <= gain_meta_reg;
    end
  end
  assign hp_short = hp_sync_reg[1];
  assign sp_short = sp_sync_reg[1];

  // third gain stage fed only by the second flop, so the first never reaches logic
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gain_hold_reg <= gain_code_rst;
    end else begin
      gain_hold_reg <= gain_sync_reg;
    end
  end
  assign gain_steady = gain_sync_reg == gain_hold_reg;

  // gain code may tear across bits; a change is only taken once two stages agree
  // this costs one cycle, invisible next to the converter's own update rate
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gain_reg <= gain_code_rst;
    end else if (gain_steady) begin
      if (gain_sync_reg == gain_code_reserved) begin
        gain_reg <= gain_code_min; // RULE_03
      end else begin
        gain_reg <= gain_sync_reg; // RULE_01 RULE_02
      end
    end
  end

  // page select, any 8-bit value accepted
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      page_reg <= page_select_rst;
    end else if (wr_page) begin
      page_reg <= wdata; // RULE_05
    end
  end

  // address decode shared by the write strobes and the read mux
  // writes to the read-only gain readout or reserved offsets decode to nothing
  assign wr_page = wr_en && addr == page_select_off;
  assign sel_gain = page_reg == gain_page && addr == pin_volume_gain_readout_off;
  assign sel_err = page_reg == driver_page && addr == driver_error_control_off;
  assign sel_hp = page_reg == driver_page && addr == headphone_driver_control_off;
  assign sel_sp = page_reg == driver_page && addr == speaker_amp_control_off;
  assign wr_err = wr_en && sel_err;
  assign wr_hp = wr_en && sel_hp;
  assign wr_sp = wr_en && sel_sp;

  // error control keeps only its two keep bits
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      err_reg <= driver_error_control_rst;
    end else if (wr_err) begin
      err_reg <= wdata & err_stored_mask;
    end
  end

  // next headphone value: write first, then the short clears power-up on top
  always_comb begin
    hp_next = hp_reg;
    if (wr_hp) begin
      hp_next = (wdata & hp_stored_mask) | (hp_reg & ~hp_stored_mask);
    end
    if (hp_short && !err_reg[hp_keep_bit] && hp_next[hp_resp_bit]) begin // RULE_07 RULE_11
      hp_next[hp_left_bit] = 1'b0; // RULE_15
      hp_next[hp_right_bit] = 1'b0;
    end
    hp_next[hp_short_bit] = hp_short; // RULE_12
  end

  // next speaker value; a short wins over a simultaneous power-up write
  always_comb begin
    sp_next = sp_reg;
    if (wr_sp) begin
      sp_next = (wdata & sp_stored_mask) | (sp_reg & ~sp_stored_mask); // RULE_14
    end
    if (sp_short && !err_reg[sp_keep_bit]) begin // RULE_08
      sp_next[sp_left_bit] = 1'b0; // RULE_15
      sp_next[sp_right_bit] = 1'b0;
    end
    sp_next[sp_short_bit] = sp_short;
  end

  // headphone driver register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hp_reg <= headphone_driver_control_rst; // RULE_09
    end else begin
      hp_reg <= hp_next;
    end
  end

  // speaker amplifier register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sp_reg <= speaker_amp_control_rst;
    end else begin
      sp_reg <= sp_next;
    end
  end

  // read mux; unmapped and reserved addresses read zero, top gain bit reads zero
  always_comb begin
    rdata_next = 8'h00;
    if (addr == page_select_off) begin
      rdata_next = page_reg;
    end else if (sel_gain) begin
      rdata_next = {1'b0, gain_reg}; // RULE_04
    end else if (sel_err) begin
      rdata_next = err_reg;
    end else if (sel_hp) begin
      rdata_next = hp_reg;
    end else if (sel_sp) begin
      rdata_next = sp_reg;
    end
  end

  // read data holds between reads, so the host may fetch it at leisure
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= rdata_next;
    end
  end

  // registered page copy for the rest of the device, one cycle behind page_reg
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      page <= page_select_rst;
    end else begin
      page <= page_reg;
    end
  end

  // driver controls come from flops; the extra cycle is harmless next to analog ramps
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drv_ctrl <= '0;
    end else begin
      drv_ctrl.left_headphone_driver <= hp_reg[hp_left_bit]; // RULE_09
      drv_ctrl.right_headphone_driver <= hp_reg[hp_right_bit];
      drv_ctrl.left_speaker_driver <= sp_reg[sp_left_bit];
      drv_ctrl.right_speaker_driver <= sp_reg[sp_right_bit];
      drv_ctrl.common_mode_sel <= hp_reg[4:3]; // RULE_10
      drv_ctrl.hp_power_down_on_short <= hp_reg[hp_resp_bit]; // RULE_11
    end
  end
endmodule : output_driver_protection_regs

// [test/analog_side_model.sv]
// far-side stand-in: short detectors and pin-volume converter levels
`timescale 1ns/1ps
module analog_side_model (
  input wire logic hp_fault,
  input wire logic sp_fault,
  input wire logic [6:0] knob,
  output logic hp_short_pin,
  output logic sp_short_pin,
  output logic [6:0] gain_code_in
);
  // detectors are level outputs, so a short holds as long as the fault does
  assign {hp_short_pin, sp_short_pin, gain_code_in} = {hp_fault, sp_fault, knob};
endmodule : analog_side_model

// [test/drv_prot_checker_assertions.sv]
// checker: bus decode and short-path assertions for the driver register bank
`timescale 1ns/1ps
module drv_prot_checker
  import drv_prot_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [7:0] page,
  input wire logic hp_short_pin,
  input wire logic sp_short_pin,
  input wire logic [6:0] gain_code_in,
  input wire drv_ctrl_t drv_ctrl
);
  logic [7:0] pg;
  logic hk, sk;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // own page and keep-bit mirror; the page port lags a cycle, too late for decode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) {pg, hk, sk} <= 10'h000;
    else if (wr_en && addr == 8'h00) pg <= wdata;
    else if (wr_en && pg == 8'h01 && addr == 8'h1e) {hk, sk} <= wdata[1:0];
  end
  chk_page_follow: assert property (wr_en && addr == 8'h00 |=> ##1 page == $past(wdata, 2))
    else $error("page lag");
  chk_gain_no_rsv: assert property (rd_en && pg == 8'h00 && addr == 8'h75 |=> rdata < 8'h7f)
    else $error("gain code");
  chk_hp_short_clr: assert property ((hp_short_pin && !hk && drv_ctrl.hp_power_down_on_short)[*5]
    |=> !drv_ctrl.left_headphone_driver && !drv_ctrl.right_headphone_driver) else $error("hp on");
  chk_sp_short_clr: assert property ((sp_short_pin && !sk)[*5]
    |=> !drv_ctrl.left_speaker_driver && !drv_ctrl.right_speaker_driver) else $error("sp on");
  chk_unmapped_zero: assert property (rd_en && addr == 8'h50 |=> rdata == 8'h00)
    else $error("unmapped");
  chk_hp_fixed_bits: assert property (rd_en && pg == 8'h01 && addr == 8'h1f |=> rdata[2] && !rdata[5])
    else $error("hp fixed");
  chk_hp_flag_set: assert property ($past(hp_short_pin, 3) && $past(hp_short_pin, 4) && rd_en
    && pg == 8'h01 && addr == 8'h1f |=> rdata[0]) else $error("hp flag");
  chk_err_upper_zero: assert property (rd_en && pg == 8'h01 && addr == 8'h1e |=> rdata[7:2] == 6'h00)
    else $error("err bits");
  chk_sp_clear_time: assert property (sp_short_pin ##2 !sk |=> ##1 !drv_ctrl.left_speaker_driver
    && !drv_ctrl.right_speaker_driver) else $error("sp late");
endmodule : drv_prot_checker
bind output_driver_protection_regs drv_prot_checker chk_i (.mclk(mclk), .nrst(nrst), .wr_en(wr_en),
  .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .page(page), .hp_short_pin(hp_short_pin),
  .sp_short_pin(sp_short_pin), .gain_code_in(gain_code_in), .drv_ctrl(drv_ctrl));

// [test/tb_output_driver_protection_regs.sv]
// testbench: register access, short-circuit clearing and gain readout
`timescale 1ns/1ps
module tb_output_driver_protection_regs;
  import drv_prot_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, hp_fault = 1'b0, sp_fault = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, page;
  logic [6:0] knob = 7'h00, gain_code_in;
  logic hp_short_pin, sp_short_pin;
  drv_ctrl_t drv_ctrl;
  int error_cnt = 0, n_checks = 0;
  logic [6:0] codes [5] = '{7'h00, 7'h23, 7'h24, 7'h7e, 7'h7f};
  logic [7:0] gains [5] = '{8'h00, 8'h23, 8'h24, 8'h7e, 8'h7e};
  output_driver_protection_regs uut (.mclk(mclk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .page(page), .hp_short_pin(hp_short_pin),
    .sp_short_pin(sp_short_pin), .gain_code_in(gain_code_in), .drv_ctrl(drv_ctrl));
  analog_side_model far (.hp_fault(hp_fault), .sp_fault(sp_fault), .knob(knob),
    .hp_short_pin(hp_short_pin), .sp_short_pin(sp_short_pin), .gain_code_in(gain_code_in));
  initial forever #50 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // strobes drop a cycle after rising, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge mclk);
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    {rd_en, addr} = {1'b1, a};
    @(negedge mclk);
    rd_en = 1'b0;
    chk(rdata, e);
  endtask : rd
  // fault held long enough to pass the two-flop synchroniser
  task automatic short_case(input logic [7:0] e, input logic [7:0] a, input logic [7:0] w,
    input logic [7:0] x);
    wr(8'h1e, e);
    wr(a, w);
    {hp_fault, sp_fault} = {a == 8'h1f, a == 8'h20};
    repeat (4) @(negedge mclk);
    rd(a, x);
    {hp_fault, sp_fault} = 2'b00;
    repeat (4) @(negedge mclk);
  endtask : short_case
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    #500000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h01);
    rd(8'h1f, 8'h04);
    rd(8'h20, 8'h06);
    rd(8'h50, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h1f, 8'hc6 | 8'(i << 3));
      @(negedge mclk);
      chk({1'b0, drv_ctrl}, {5'b01100, i[1:0], 1'b1});
    end
    wr(8'h20, 8'hc6);
    @(negedge mclk);
    chk({1'b0, drv_ctrl}, 8'h7f);
    short_case(8'h00, 8'h1f, 8'hc6, 8'h07);
    short_case(8'h02, 8'h1f, 8'hc6, 8'hc7);
    short_case(8'h00, 8'h1f, 8'hc4, 8'hc5);
    short_case(8'h00, 8'h20, 8'hc6, 8'h07);
    short_case(8'h01, 8'h20, 8'hc6, 8'hc7);
    $display("test short response done");
    wr(8'h00, 8'h00);
    wr(8'h75, 8'h00);
    for (int i = 0; i < 5; i++) begin
      knob = codes[i];
      repeat (6) @(negedge mclk);
      rd(8'h75, gains[i]);
    end
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hff);
    rd(8'h1f, 8'h00);
    $display("test gain and page done");
    conclude();
  end
endmodule : tb_output_driver_protection_regs
